// file: meter_cfg_pkg.sv
/*
  Shared constants and types for the metering configuration bank:
  register offsets, field positions, reset values, gain and angle encodings.
  Assumes a 16-bit register port driven by the host serial interface.
*/
package meter_cfg_pkg;

  localparam int          REG_W              = 16;
  localparam int          ADDR_W             = 16;
  localparam logic [15:0] COMP_MODE_ADDR     = 16'he60e;
  localparam logic [15:0] CHAN_GAIN_ADDR     = 16'he60f;

  // Computation mode fields
  localparam int          TERM_SEL_LSB       = 0;
  localparam int          TERM_SEL_W         = 9;
  localparam int          ANGLE_SEL_LSB      = 9;
  localparam int          NOM_A_BIT          = 11;
  localparam int          NOM_B_BIT          = 12;
  localparam int          NOM_C_BIT          = 13;
  localparam int          LINE_FREQ_BIT      = 14;
  localparam int          COMP_RSVD_BIT      = 15;
  localparam logic [15:0] COMP_MODE_RESET    = 16'h01ff;
  localparam logic [15:0] COMP_MODE_WMASK    = 16'h7fff;

  // Gain fields
  localparam int          I_GAIN_LSB         = 0;
  localparam int          N_GAIN_LSB         = 3;
  localparam int          V_GAIN_LSB         = 6;
  localparam logic [15:0] CHAN_GAIN_RESET    = 16'h0000;
  localparam logic [15:0] CHAN_GAIN_WMASK    = 16'h01ff;
  localparam logic [15:0] NEUTRAL_FIELD_MASK = 16'h0038;

  localparam int          NOM_VOLT_W         = 24;

  typedef enum logic [1:0] {
    ANGLE_VOLT_CURR = 2'h0,
    ANGLE_VOLT_ONLY = 2'h1,
    ANGLE_CURR_ONLY = 2'h2,
    ANGLE_NONE      = 2'h3
  } angle_sel_t;

  typedef enum logic [2:0] {
    GAIN_X1  = 3'h0,
    GAIN_X2  = 3'h1,
    GAIN_X4  = 3'h2,
    GAIN_X8  = 3'h3,
    GAIN_X16 = 3'h4
  } gain_code_t;

  // Effective settings handed to the datapath
  typedef struct packed {
    logic       angle_volt_curr;
    logic       angle_volt_volt;
    logic       angle_curr_curr;
    logic [2:0] nominal_sel;
    logic       line_freq_60;
    logic [8:0] term_sel;
  } mode_ctl_t;

  typedef struct packed {
    logic [4:0] phase_current_gain;
    logic [4:0] neutral_current_gain;
    logic [4:0] phase_voltage_gain;
  } gain_ctl_t;

endpackage : meter_cfg_pkg

// file: gain_decode.sv
/*
  Decodes a three-bit gain code into a one-hot shift select (x1..x16).
  Assumes the code comes from a register on the same clock.
*/
`timescale 1ns/10ps
module gain_decode
(
  input  wire logic [2:0] code,
  output logic      [4:0] onehot
);

  always_comb
  begin
    unique case (code)
      meter_cfg_pkg::GAIN_X2:  onehot = 5'h02;
      meter_cfg_pkg::GAIN_X4:  onehot = 5'h04;
      meter_cfg_pkg::GAIN_X8:  onehot = 5'h08;
      meter_cfg_pkg::GAIN_X16: onehot = 5'h10;
      // Reserved codes act exactly like gain 1
      default:                 onehot = 5'h01;
    endcase
  end

endmodule : gain_decode

// file: nominal_volt_mux.sv
/*
  Per-phase choice between measured rms voltage and the nominal value.
  Assumes measured rms and nominal value are on the same clock.
*/
`timescale 1ns/10ps
module nominal_volt_mux #(
  parameter int W = 24
)
(
  input  wire logic [2:0]     sel,
  input  wire logic [3*W-1:0] measured,
  input  wire logic [W-1:0]   nominal,
  output logic      [3*W-1:0] used
);

  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    assign used[p*W +: W] = sel[p] ? nominal : measured[p*W +: W];
  end

endmodule : nominal_volt_mux

// file: meter_mode_gain_config.sv
/*
  Computation mode and channel gain configuration registers of the metering
  core, with decoded controls and per-phase voltage selection for the datapath.
  Assumes a same-clock host register port: one-cycle strobes, read data next cycle.
*/
// The plain strobed port was decided locally.
// Contract
// - Angle select 00 (the reset value) measures voltage-to-current angles per phase.
// - Angle select 01 measures angles between phase voltages only.
// - Angle select 10 measures angles between phase currents only.
// - Angle select 11 disables all angle measurement.
// - Phase A nominal enable substitutes the nominal voltage for every phase A rms use.
// - Phase B nominal enable substitutes the nominal voltage for every phase B rms use.
// - Phase C nominal enable substitutes the nominal voltage for every phase C rms use.
// - Mode bit 15 resets to zero and controls nothing.
// - Phase current gain codes 0..4 give x1..x16, codes 5..7 act as x1.
// - Neutral current gain codes 0..4 give x1..x16, codes 5..7 act as x1.
// - Without a neutral channel the neutral gain field stays 000.
// - Phase voltage gain codes 0..4 give x1..x16, codes 5..7 act as x1.
// - Gain bits 15:9 reset to zero and control nothing.
`timescale 1ns/10ps
module meter_mode_gain_config #(
  parameter bit HAS_NEUTRAL = 1'b1,
  parameter int NOM_W       = meter_cfg_pkg::NOM_VOLT_W
)
(
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic [meter_cfg_pkg::ADDR_W-1:0]  addr,
  input  wire logic [meter_cfg_pkg::REG_W-1:0]   wdata,
  input  wire logic                              wr_strobe,
  input  wire logic                              rd_strobe,
  input  wire logic [3*NOM_W-1:0]                measured_rms,
  input  wire logic [NOM_W-1:0]                  nominal_voltage_value,
  output logic      [meter_cfg_pkg::REG_W-1:0]   rdata,
  output meter_cfg_pkg::mode_ctl_t               mode_ctl,
  output meter_cfg_pkg::gain_ctl_t               gain_ctl,
  output logic      [3*NOM_W-1:0]                rms_used
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] computation_mode_cfg_reg;
  logic [15:0] computation_mode_cfg_next;
  logic [15:0] channel_gain_cfg_reg;
  logic [15:0] channel_gain_cfg_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        hit_mode;
  logic        hit_gain;
  logic [15:0] gain_keep_mask;

  assign hit_mode       = (addr == meter_cfg_pkg::COMP_MODE_ADDR);
  assign hit_gain       = (addr == meter_cfg_pkg::CHAN_GAIN_ADDR);
  // Neutral field is not writable on parts without a neutral channel
  assign gain_keep_mask = HAS_NEUTRAL ? meter_cfg_pkg::CHAN_GAIN_WMASK
                        : (meter_cfg_pkg::CHAN_GAIN_WMASK & ~meter_cfg_pkg::NEUTRAL_FIELD_MASK);

  always_comb
  begin
    computation_mode_cfg_next = computation_mode_cfg_reg;
    channel_gain_cfg_next     = channel_gain_cfg_reg;
    rdata_next                = 16'h0000;
    if (wr_strobe && hit_mode)
    begin
      // Bit 15 is never stored, so it stays zero
      computation_mode_cfg_next = wdata & meter_cfg_pkg::COMP_MODE_WMASK;
    end
    if (wr_strobe && hit_gain)
    begin
      channel_gain_cfg_next = wdata & gain_keep_mask;
    end
    if (rd_strobe)
    begin
      // Unmapped addresses read as zero
      if (hit_mode)
        rdata_next = computation_mode_cfg_reg;
      else if (hit_gain)
        rdata_next = channel_gain_cfg_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      computation_mode_cfg_reg <= meter_cfg_pkg::COMP_MODE_RESET;
      channel_gain_cfg_reg     <= meter_cfg_pkg::CHAN_GAIN_RESET;
      rdata_reg                <= 16'h0000;
    end
    else
    begin
      computation_mode_cfg_reg <= computation_mode_cfg_next;
      channel_gain_cfg_reg     <= channel_gain_cfg_next;
      rdata_reg                <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls, registered so the datapath sees clean levels

  meter_cfg_pkg::mode_ctl_t mode_ctl_reg;
  meter_cfg_pkg::mode_ctl_t mode_ctl_next;
  meter_cfg_pkg::gain_ctl_t gain_ctl_reg;
  meter_cfg_pkg::gain_ctl_t gain_ctl_next;
  meter_cfg_pkg::angle_sel_t angle_measure_select;
  logic [4:0]  i_gain_oh;
  logic [4:0]  n_gain_oh;
  logic [4:0]  v_gain_oh;

  assign angle_measure_select = meter_cfg_pkg::angle_sel_t'(
    computation_mode_cfg_reg[meter_cfg_pkg::ANGLE_SEL_LSB +: 2]);

  gain_decode u_i_gain
  (
    .code   (channel_gain_cfg_reg[meter_cfg_pkg::I_GAIN_LSB +: 3]),
    .onehot (i_gain_oh)
  );

  gain_decode u_n_gain
  (
    .code   (channel_gain_cfg_reg[meter_cfg_pkg::N_GAIN_LSB +: 3]),
    .onehot (n_gain_oh)
  );

  gain_decode u_v_gain
  (
    .code   (channel_gain_cfg_reg[meter_cfg_pkg::V_GAIN_LSB +: 3]),
    .onehot (v_gain_oh)
  );

  always_comb
  begin
    mode_ctl_next = '0;
    unique case (angle_measure_select)
      meter_cfg_pkg::ANGLE_VOLT_CURR: mode_ctl_next.angle_volt_curr = 1'b1;
      meter_cfg_pkg::ANGLE_VOLT_ONLY: mode_ctl_next.angle_volt_volt = 1'b1;
      meter_cfg_pkg::ANGLE_CURR_ONLY: mode_ctl_next.angle_curr_curr = 1'b1;
      meter_cfg_pkg::ANGLE_NONE:      mode_ctl_next.angle_volt_curr = 1'b0;
    endcase
    mode_ctl_next.nominal_sel  = computation_mode_cfg_reg[meter_cfg_pkg::NOM_C_BIT:meter_cfg_pkg::NOM_A_BIT];
    // Only meaningful on fundamental-only variants; passed through regardless
    mode_ctl_next.line_freq_60 = computation_mode_cfg_reg[meter_cfg_pkg::LINE_FREQ_BIT];
    mode_ctl_next.term_sel     = computation_mode_cfg_reg[meter_cfg_pkg::TERM_SEL_LSB +: meter_cfg_pkg::TERM_SEL_W];
    gain_ctl_next.phase_current_gain   = i_gain_oh;
    gain_ctl_next.neutral_current_gain = HAS_NEUTRAL ? n_gain_oh : 5'h01;
    gain_ctl_next.phase_voltage_gain   = v_gain_oh;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_ctl_reg <= '{angle_volt_curr: 1'b1, term_sel: 9'h1ff, default: '0};
      gain_ctl_reg <= '{5'h01, 5'h01, 5'h01};
    end
    else
    begin
      mode_ctl_reg <= mode_ctl_next;
      gain_ctl_reg <= gain_ctl_next;
    end
  end

  assign mode_ctl = mode_ctl_reg;
  assign gain_ctl = gain_ctl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase rms voltage substitution

  logic [3*NOM_W-1:0] rms_used_reg;
  logic [3*NOM_W-1:0] rms_used_next;

  nominal_volt_mux #(
    .W (NOM_W)
  ) u_nom_mux
  (
    .sel      (computation_mode_cfg_reg[meter_cfg_pkg::NOM_C_BIT:meter_cfg_pkg::NOM_A_BIT]),
    .measured (measured_rms),
    .nominal  (nominal_voltage_value),
    .used     (rms_used_next)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rms_used_reg <= '0;
    else
      rms_used_reg <= rms_used_next;
  end

  assign rms_used = rms_used_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mode_bit15_zero_a: assert property (computation_mode_cfg_reg[meter_cfg_pkg::COMP_RSVD_BIT] == 1'b0)
    else $error("Mode reserved bit set");
  gain_rsvd_zero_a: assert property (channel_gain_cfg_reg[15:9] == 7'h00)
    else $error("Gain reserved bits set");
  neutral_fixed_a: assert property (!HAS_NEUTRAL |-> channel_gain_cfg_reg[5:3] == 3'h0)
    else $error("Neutral gain field not zero");
  angle_vc_a: assert property (angle_measure_select == meter_cfg_pkg::ANGLE_VOLT_CURR |=> mode_ctl.angle_volt_curr)
    else $error("Voltage-current angle not selected");
  angle_vv_a: assert property (angle_measure_select == meter_cfg_pkg::ANGLE_VOLT_ONLY
                              |=> mode_ctl.angle_volt_volt && !mode_ctl.angle_volt_curr)
    else $error("Voltage angle not selected");
  angle_cc_a: assert property (angle_measure_select == meter_cfg_pkg::ANGLE_CURR_ONLY
                              |=> mode_ctl.angle_curr_curr && !mode_ctl.angle_volt_volt)
    else $error("Current angle not selected");
  angle_none_a: assert property (angle_measure_select == meter_cfg_pkg::ANGLE_NONE
                                |=> !mode_ctl.angle_volt_curr && !mode_ctl.angle_volt_volt && !mode_ctl.angle_curr_curr)
    else $error("Angle active when disabled");
  nom_a_used_a: assert property (computation_mode_cfg_reg[meter_cfg_pkg::NOM_A_BIT]
                                |=> rms_used[NOM_W-1:0] == $past(nominal_voltage_value))
    else $error("Phase A nominal not used");
  nom_b_used_a: assert property (computation_mode_cfg_reg[meter_cfg_pkg::NOM_B_BIT]
                                |=> rms_used[NOM_W +: NOM_W] == $past(nominal_voltage_value))
    else $error("Phase B nominal not used");
  nom_c_meas_a: assert property (!computation_mode_cfg_reg[meter_cfg_pkg::NOM_C_BIT]
                                |=> rms_used[2*NOM_W +: NOM_W] == $past(measured_rms[2*NOM_W +: NOM_W]))
    else $error("Phase C measured not used");
  i_gain_map_a: assert property (channel_gain_cfg_reg[2:0] > 3'h4 |=> gain_ctl.phase_current_gain == 5'h01)
    else $error("Reserved current gain not x1");
  n_gain_map_a: assert property (HAS_NEUTRAL && channel_gain_cfg_reg[5:3] == 3'h4
                                |=> gain_ctl.neutral_current_gain == 5'h10)
    else $error("Neutral gain x16 wrong");
  v_gain_map_a: assert property (channel_gain_cfg_reg[8:6] == 3'h3 |=> gain_ctl.phase_voltage_gain == 5'h08)
    else $error("Voltage gain x8 wrong");
  wr_rd_back_a: assert property (wr_strobe && hit_mode ##1 rd_strobe && hit_mode && !wr_strobe
                                |=> rdata == ($past(wdata, 2) & meter_cfg_pkg::COMP_MODE_WMASK))
    else $error("Mode readback mismatch");
  freq_pass_a: assert property (mode_ctl.line_freq_60 == $past(computation_mode_cfg_reg[14]))
    else $error("Line frequency not passed");

  wr_mode_c:  cover property (wr_strobe && hit_mode);
  wr_gain_c:  cover property (wr_strobe && hit_gain ##1 rd_strobe && hit_gain);
  angle_off_c: cover property (angle_measure_select == meter_cfg_pkg::ANGLE_NONE);
  all_nom_c:  cover property (computation_mode_cfg_reg[13:11] == 3'h7);

endmodule : meter_mode_gain_config

// file: meter_mode_gain_config_test.sv
/*
  Self-checking testbench for the computation mode and channel gain bank.
  Assumes the design package and modules are compiled first and one 100 MHz clock.
*/
`timescale 1ns/10ps
module meter_mode_gain_config_test;
  localparam int W = meter_cfg_pkg::NOM_VOLT_W;

  logic                      clk;
  logic                      rst_n;
  logic [15:0]               addr;
  logic [15:0]               wdata;
  logic                      wr_strobe;
  logic                      rd_strobe;
  logic [3*W-1:0]            measured_rms;
  logic [W-1:0]              nominal_voltage_value;
  logic [15:0]               rdata;
  logic [15:0]               rdata_nn;
  meter_cfg_pkg::mode_ctl_t  mode_ctl;
  meter_cfg_pkg::gain_ctl_t  gain_ctl;
  meter_cfg_pkg::gain_ctl_t  gain_ctl_nn;
  logic [3*W-1:0]            rms_used;
  logic [15:0]               m;
  logic [15:0]               g;
  int                        n_fail;
  int                        compares;

  meter_mode_gain_config #(.HAS_NEUTRAL(1'b1), .NOM_W(W)) u_meter_mode_gain_config (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .measured_rms(measured_rms), .nominal_voltage_value(nominal_voltage_value), .rdata(rdata),
    .mode_ctl(mode_ctl), .gain_ctl(gain_ctl), .rms_used(rms_used));

  // Variant without a neutral channel shares every input
  meter_mode_gain_config #(.HAS_NEUTRAL(1'b0), .NOM_W(W)) u_meter_mode_gain_config_nn (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .measured_rms(measured_rms), .nominal_voltage_value(nominal_voltage_value), .rdata(rdata_nn),
    .mode_ctl(), .gain_ctl(gain_ctl_nn), .rms_used());

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] onehot(input logic [2:0] c);
    return (c > 3'h4) ? 5'h01 : (5'h01 << c);
  endfunction : onehot

  function automatic meter_cfg_pkg::mode_ctl_t exp_mode(input logic [15:0] r);
    meter_cfg_pkg::mode_ctl_t e;
    e.angle_volt_curr = (r[10:9] == 2'h0);
    e.angle_volt_volt = (r[10:9] == 2'h1);
    e.angle_curr_curr = (r[10:9] == 2'h2);
    e.nominal_sel     = r[13:11];
    e.line_freq_60    = r[14];
    e.term_sel        = r[8:0];
    return e;
  endfunction : exp_mode

  function automatic meter_cfg_pkg::gain_ctl_t exp_gain(input logic [15:0] r, input logic nn);
    meter_cfg_pkg::gain_ctl_t e;
    e.phase_current_gain   = onehot(r[2:0]);
    e.neutral_current_gain = nn ? onehot(r[5:3]) : 5'h01;
    e.phase_voltage_gain   = onehot(r[8:6]);
    return e;
  endfunction : exp_gain

  function automatic logic [3*W-1:0] exp_rms(input logic [2:0] sel);
    logic [3*W-1:0] e;
    e = measured_rms;
    for (int p = 0; p < 3; p++)
      if (sel[p])
        e[p*W +: W] = nominal_voltage_value;
    return e;
  endfunction : exp_rms

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_reg

  task automatic check_ctl(input string name, input logic [71:0] exp, input logic [71:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_ctl

  // Called just after a clock edge, so a read may follow a write with no gap
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    addr      <= a;
    wdata     <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : reg_write

  // Checks both variants, then that rdata of the neutral variant alone falls back to zero
  task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    check_reg("rdata", exp, rdata);
    check_reg("rdata no neutral", (a == meter_cfg_pkg::CHAN_GAIN_ADDR) ?
              (exp & ~meter_cfg_pkg::NEUTRAL_FIELD_MASK) : exp, rdata_nn);
    @(posedge clk);
    #1;
    check_reg("rdata idle", 16'h0000, rdata);
  endtask : reg_read

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #50us;
    n_fail++;
    complete_run();
  end

  initial
  begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    measured_rms = 72'hccc333_bbb222_aaa111;
    nominal_voltage_value = 24'h5a5a5a;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check_ctl("mode_ctl reset", 72'(exp_mode(meter_cfg_pkg::COMP_MODE_RESET)), 72'(mode_ctl));
    check_ctl("gain_ctl reset", 72'(exp_gain(16'h0000, 1'b1)), 72'(gain_ctl));
    reg_read(meter_cfg_pkg::COMP_MODE_ADDR, 16'h01ff);
    reg_read(meter_cfg_pkg::CHAN_GAIN_ADDR, 16'h0000);
    $display("test reset values done");

    for (int i = 0; i < 8; i++)
    begin
      m = {1'b1, i[0], i[2:0], i[1:0], 9'h0a5 ^ 9'(i)};
      reg_write(meter_cfg_pkg::COMP_MODE_ADDR, m);
      reg_read(meter_cfg_pkg::COMP_MODE_ADDR, m & meter_cfg_pkg::COMP_MODE_WMASK);
      check_ctl("mode_ctl", 72'(exp_mode(m)), 72'(mode_ctl));
      check_ctl("rms_used", exp_rms(m[13:11]), rms_used);
    end
    $display("test computation mode done");

    for (int c = 0; c < 8; c++)
    begin
      g = {7'h7f, 3'(c + 2), 3'(c + 1), 3'(c)};
      reg_write(meter_cfg_pkg::CHAN_GAIN_ADDR, g);
      settle();
      check_ctl("gain_ctl", 72'(exp_gain(g, 1'b1)), 72'(gain_ctl));
      check_ctl("gain_ctl no neutral", 72'(exp_gain(g, 1'b0)), 72'(gain_ctl_nn));
      reg_read(meter_cfg_pkg::CHAN_GAIN_ADDR, g & meter_cfg_pkg::CHAN_GAIN_WMASK);
    end
    $display("test channel gain done");

    reg_write(16'he610, 16'hffff);
    reg_read(16'he610, 16'h0000);
    reg_read(meter_cfg_pkg::COMP_MODE_ADDR, m & meter_cfg_pkg::COMP_MODE_WMASK);
    reg_read(meter_cfg_pkg::CHAN_GAIN_ADDR, g & meter_cfg_pkg::CHAN_GAIN_WMASK);
    $display("test unmapped address done");

    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check_ctl("mode_ctl second reset", 72'(exp_mode(meter_cfg_pkg::COMP_MODE_RESET)), 72'(mode_ctl));
    reg_read(meter_cfg_pkg::COMP_MODE_ADDR, 16'h01ff);
    reg_read(meter_cfg_pkg::CHAN_GAIN_ADDR, 16'h0000);
    $display("test second reset done");
    complete_run();
  end
endmodule : meter_mode_gain_config_test
